// file: design/remote_output_latch.v
/*
  Remote output latch: a 12-bit data word written by the host over the
  parameter port drives the output terminals assigned the remote output
  function, with a retention selection governing power-off and inverter reset.
  Assumes i_rst_n is the power-on reset, reset and power-off events are
  one-cycle pulses synchronous to i_ref_clk, and the terminal function
  selections are held by the surrounding parameter logic.
*/
// Function
// RULE_01: Selection 0 or 10 clears data at power-on.
// RULE_02: Selection 1 or 11 saves, restores at power-on.
// RULE_03: Inverter reset never writes non-volatile store.
// RULE_04: Inverter reset clears data word by default.
// RULE_05: Selection 1 reloads saved word at inverter reset.
// RULE_06: Selection 10 or 11 holds data across reset.
// RULE_07: Data word twelve bits, initial value zero.
// RULE_08: Host selects 96 or 196 for remote.
// RULE_09: Data bit drives terminal, inverted for negative logic.
// RULE_10: Bit 0 controls the run-status terminal.
// RULE_11: Unassigned terminals ignore data, follow own function.
// RULE_12: Host writes apply to the terminals.
// RULE_13: Writes accepted in every mode, no protection.
`timescale 1ns/1ps
`default_nettype none
`include "remote_output_latch_regs.vh"

module remote_output_latch (
  input wire i_ref_clk, // Core clock, 250 MHz.
  input wire i_rst_n, // Power-on reset, active low.
  input wire i_nv_rst_n, // Erase of the non-volatile store, active low.
  input wire i_power_off, // Power-off warning pulse.
  input wire i_term_reset, // Terminal reset pulse.
  input wire i_comm_reset, // Communication reset request pulse.
  input wire i_reg_wr, // Parameter write request.
  input wire i_reg_rd, // Parameter read request.
  input wire [1:0] i_reg_idx, // Parameter index.
  input wire [`RO_BITS_W-1:0] i_reg_wdata, // Parameter write value.
  output wire [`RO_BITS_W-1:0] o_reg_rdata, // Parameter read value.
  output wire o_reg_ack, // Request done pulse.
  output wire o_reg_err, // Request refused, with the ack.
  input wire [8*`RO_TERM_COUNT-1:0] i_term_func_sel, // Function code per terminal.
  input wire [`RO_TERM_COUNT-1:0] i_term_func_state, // Own function level per terminal.
  output wire [`RO_TERM_COUNT-1:0] o_term, // Terminal output levels.
  output wire o_busy // Restore after power-on in progress.
);

  localparam [1:0] ST_RESTORE = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;
  localparam [4*`RO_TERM_COUNT-1:0] TERM_BIT_MAP = `RO_TERM_BIT_MAP;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [`RO_SEL_W-1:0] sel_q;
  reg [`RO_SEL_W-1:0] sel_d;
  reg [`RO_BITS_W-1:0] bits_q;
  reg [`RO_BITS_W-1:0] bits_d;
  reg [`RO_BITS_W-1:0] rdata_q;
  reg [`RO_BITS_W-1:0] rdata_d;
  reg ack_q;
  reg err_q;
  reg err_d;
  reg [`RO_TERM_COUNT-1:0] term_q;
  wire [`RO_TERM_COUNT-1:0] term_d;

  wire [`RO_SEL_W-1:0] nv_sel;
  wire [`RO_BITS_W-1:0] nv_bits;
  wire nv_sel_we;
  wire nv_bits_we;

  wire running;
  wire inv_reset;
  wire req;
  wire wr_take;
  wire wdata_sel_legal;
  wire sel_saves;
  wire sel_holds;
  wire nv_sel_saves;
  wire hit_sel;
  wire hit_bits;
  reg [`RO_BITS_W-1:0] status_word;

  // Both reset sources act alike; neither reaches the store.
  assign inv_reset = i_term_reset | i_comm_reset;
  assign running = st_q[1];
  assign req = i_reg_wr | i_reg_rd;
  // No write-protect or operation-mode gating: the data word is writable in every cycle but the restore cycle.
  assign wr_take = running & i_reg_wr; // RULE_13

  assign wdata_sel_legal = (i_reg_wdata[`RO_BITS_W-1:`RO_SEL_W] == 4'h0) &&
    ((i_reg_wdata[`RO_SEL_W-1:0] == `RO_SEL_CLEAR_CLEAR) ||
     (i_reg_wdata[`RO_SEL_W-1:0] == `RO_SEL_SAVE_CLEAR) ||
     (i_reg_wdata[`RO_SEL_W-1:0] == `RO_SEL_CLEAR_HOLD) ||
     (i_reg_wdata[`RO_SEL_W-1:0] == `RO_SEL_SAVE_HOLD));

  assign sel_saves = (sel_q == `RO_SEL_SAVE_CLEAR) || (sel_q == `RO_SEL_SAVE_HOLD);
  assign sel_holds = (sel_q == `RO_SEL_CLEAR_HOLD) || (sel_q == `RO_SEL_SAVE_HOLD);
  assign nv_sel_saves = (nv_sel == `RO_SEL_SAVE_CLEAR) || (nv_sel == `RO_SEL_SAVE_HOLD);

  // Index decode shared by the latch and the store.
  assign hit_sel = (i_reg_idx == `RO_IDX_RETENTION);
  assign hit_bits = (i_reg_idx == `RO_IDX_BITS);

  // The selection itself is a stored parameter, so it outlives power cycles.
  assign nv_sel_we = wr_take && hit_sel && wdata_sel_legal;
  // Only a power-off saves the word; resets leave the store alone.
  assign nv_bits_we = running & i_power_off & sel_saves; // RULE_02 RULE_03

  nv_store u_nv_store (
    .i_ref_clk(i_ref_clk),
    .i_nv_rst_n(i_nv_rst_n),
    .i_sel_we(nv_sel_we),
    .i_sel_wdata(i_reg_wdata[`RO_SEL_W-1:0]),
    .i_bits_we(nv_bits_we),
    .i_bits_wdata(bits_q),
    .o_sel(nv_sel),
    .o_bits(nv_bits)
  );

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RESTORE: begin
        st_d = ST_RUN;
      end
      ST_RUN: begin
        st_d = ST_RUN;
      end
      default: begin
        st_d = ST_RESTORE;
      end
    endcase
  end

  // Latch and selection. A write in the same cycle as an inverter reset is
  // applied after the reset, so the host's value is never lost to it.
  always @* begin
    sel_d = sel_q;
    bits_d = bits_q;
    case (st_q)
      ST_RESTORE: begin
        sel_d = nv_sel;
        if (nv_sel_saves) begin
          bits_d = nv_bits; // RULE_02
        end else begin
          bits_d = `RO_BITS_RST; // RULE_01
        end
      end
      ST_RUN: begin
        if (inv_reset) begin
          if (sel_holds) begin
            bits_d = bits_q; // RULE_06
          end else if (sel_saves) begin
            bits_d = nv_bits; // RULE_05
          end else begin
            bits_d = `RO_BITS_RST; // RULE_04
          end
        end
        if (wr_take && hit_bits) begin
          bits_d = i_reg_wdata; // RULE_07 RULE_12
        end
        if (nv_sel_we) begin
          sel_d = i_reg_wdata[`RO_SEL_W-1:0];
        end
      end
      default: begin
        sel_d = `RO_RETENTION_RST;
        bits_d = `RO_BITS_RST;
      end
    endcase
  end

  // Status fields sit at their own positions; the unused bit stays zero.
  always @* begin
    status_word = `RO_BITS_RST;
    status_word[`RO_STAT_TERM_LSB +: `RO_TERM_COUNT] = term_q;
    status_word[`RO_STAT_BUSY_BIT] = ~running;
    status_word[`RO_STAT_SEL_LSB +: `RO_SEL_W] = sel_q;
  end

  // Answer to a request: reads return the register, refusals raise the error.
  always @* begin
    rdata_d = rdata_q;
    err_d = 1'b0;
    if (req) begin
      if (!running) begin
        err_d = 1'b1;
      end else if (i_reg_wr) begin
        case (i_reg_idx)
          `RO_IDX_RETENTION: begin
            err_d = ~wdata_sel_legal;
          end
          `RO_IDX_BITS: begin
            err_d = 1'b0;
          end
          default: begin
            err_d = 1'b1;
          end
        endcase
      end else begin
        case (i_reg_idx)
          `RO_IDX_RETENTION: begin
            rdata_d = {4'h0, sel_q};
          end
          `RO_IDX_BITS: begin
            rdata_d = bits_q;
          end
          `RO_IDX_STATUS: begin
            rdata_d = status_word;
          end
          default: begin
            rdata_d = `RO_BITS_RST;
            err_d = 1'b1;
          end
        endcase
      end
    end
  end

  // Each terminal picks its data bit when handed to the remote function,
  // otherwise passes its own function through untouched.
  genvar g;
  generate
    for (g = 0; g < `RO_TERM_COUNT; g = g + 1) begin : g_term
      wire [7:0] fsel;
      wire [3:0] bidx;
      wire rbit;
      wire is_pos;
      wire is_neg;
      assign fsel = i_term_func_sel[8*g +: 8];
      assign bidx = TERM_BIT_MAP[4*g +: 4];
      // Terminal 0 is the run-status terminal and takes bit 0.
      assign rbit = bits_q[bidx]; // RULE_10
      assign is_pos = (fsel == `RO_FUNC_REMOTE_POS); // RULE_08
      assign is_neg = (fsel == `RO_FUNC_REMOTE_NEG); // RULE_08
      assign term_d[g] = is_pos ? rbit : // RULE_09
                         is_neg ? ~rbit : // RULE_09
                         i_term_func_state[g]; // RULE_11
    end
  endgenerate

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_RESTORE;
      sel_q <= `RO_RETENTION_RST;
      bits_q <= `RO_BITS_RST; // RULE_07
      rdata_q <= `RO_BITS_RST;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      term_q <= `RO_TERM_RST;
    end else begin
      st_q <= st_d;
      sel_q <= sel_d;
      bits_q <= bits_d;
      rdata_q <= rdata_d;
      ack_q <= req;
      err_q <= err_d;
      term_q <= term_d; // RULE_12
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_ack = ack_q;
  assign o_reg_err = err_q;
  assign o_term = term_q;
  assign o_busy = st_q[0];

endmodule // remote_output_latch
`default_nettype wire

// file: design/remote_output_latch_regs.vh
/*
  Constants of the remote output latch: register indices, reset values,
  retention selections, terminal function codes and the terminal bit map.
  Assumes it is included by its bare name from the design files.
*/
`ifndef REMOTE_OUTPUT_LATCH_REGS_VH
`define REMOTE_OUTPUT_LATCH_REGS_VH

// Register indices on the parameter port.
`define RO_IDX_RETENTION 2'h0
`define RO_IDX_BITS 2'h1
`define RO_IDX_STATUS 2'h2

// Widths and reset values.
`define RO_BITS_W 12
`define RO_SEL_W 8
`define RO_TERM_COUNT 2
`define RO_RETENTION_RST 8'h00
`define RO_BITS_RST 12'h000
`define RO_TERM_RST 2'h0

// Retention selections: power-off behaviour and inverter-reset behaviour.
`define RO_SEL_CLEAR_CLEAR 8'h00
`define RO_SEL_SAVE_CLEAR 8'h01
`define RO_SEL_CLEAR_HOLD 8'h0A
`define RO_SEL_SAVE_HOLD 8'h0B

// Terminal function codes that hand a terminal to the remote output function.
`define RO_FUNC_REMOTE_POS 8'h60
`define RO_FUNC_REMOTE_NEG 8'hC4

// Data bit driving each terminal, four bits per terminal, terminal 0 lowest.
`define RO_TERM_BIT_MAP 8'h10

// Status register fields.
`define RO_STAT_TERM_LSB 0
`define RO_STAT_BUSY_BIT 2
`define RO_STAT_SEL_LSB 4

`endif

// file: design/nv_store.v
/*
  Non-volatile store of the remote output latch: keeps the retention
  selection and the data word saved at power-off.
  Assumes i_nv_rst_n is asserted only to erase the store, never at an
  ordinary power cycle, so the contents outlive the power-on reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "remote_output_latch_regs.vh"

module nv_store (
  input wire i_ref_clk, // Core clock.
  input wire i_nv_rst_n, // Erase of the store, active low.
  input wire i_sel_we, // Write retention selection.
  input wire [`RO_SEL_W-1:0] i_sel_wdata, // Retention selection to keep.
  input wire i_bits_we, // Save data word.
  input wire [`RO_BITS_W-1:0] i_bits_wdata, // Data word to keep.
  output wire [`RO_SEL_W-1:0] o_sel, // Stored retention selection.
  output wire [`RO_BITS_W-1:0] o_bits // Stored data word.
);

  reg [`RO_SEL_W-1:0] sel_q;
  reg [`RO_BITS_W-1:0] bits_q;

  always @(posedge i_ref_clk or negedge i_nv_rst_n) begin
    if (!i_nv_rst_n) begin
      sel_q <= `RO_RETENTION_RST;
      bits_q <= `RO_BITS_RST;
    end else begin
      if (i_sel_we) begin
        sel_q <= i_sel_wdata;
      end
      if (i_bits_we) begin
        bits_q <= i_bits_wdata;
      end
    end
  end

  assign o_sel = sel_q;
  assign o_bits = bits_q;

endmodule // nv_store
`default_nettype wire

// file: tb/remote_output_latch_assertions.sv
/* Port checker of the remote output latch.
   Assumes it is bound into remote_output_latch. */
`timescale 1ns/1ps
`default_nettype none
module rol_checker (
  input wire i_ref_clk, // Clock.
  input wire i_rst_n, // Reset.
  input wire i_reg_wr, // Write.
  input wire i_reg_rd, // Read.
  input wire [1:0] i_reg_idx, // Index.
  input wire [11:0] i_reg_wdata, // Write data.
  input wire [11:0] o_reg_rdata, // Read data.
  input wire o_reg_ack, // Done.
  input wire o_reg_err, // Refused.
  input wire [15:0] i_term_func_sel, // Codes.
  input wire [1:0] i_term_func_state, // Own levels.
  input wire [1:0] o_term, // Terminals.
  input wire o_busy // Restore.
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire rq = i_reg_wr || i_reg_rd;
  wire wb = i_reg_wr && i_reg_idx == 2'h1 && !o_busy;
  property p_ack; rq |=> o_reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_noack; o_reg_ack |-> $past(rq); endproperty
  a_noack: assert property (p_noack) else $error("stray ack");
  property p_busy_ref; rq && o_busy |=> o_reg_err; endproperty
  a_busy_ref: assert property (p_busy_ref) else $error("busy request taken");
  property p_wok; wb |=> o_reg_ack && !o_reg_err; endproperty
  a_wok: assert property (p_wok) else $error("word write refused");
  property p_rst; $rose(i_rst_n) |-> o_busy ##1 !o_busy; endproperty
  a_rst: assert property (p_rst) else $error("restore length");
  property p_pos;
    wb && i_term_func_sel[7:0] == 8'h60 ##1 i_term_func_sel[7:0] == 8'h60 |=> o_term[0] == $past(i_reg_wdata[0], 2);
  endproperty
  a_pos: assert property (p_pos) else $error("positive terminal");
  property p_neg;
    wb && i_term_func_sel[15:8] == 8'hC4 ##1 i_term_func_sel[15:8] == 8'hC4 |=> o_term[1] == !$past(i_reg_wdata[1], 2);
  endproperty
  a_neg: assert property (p_neg) else $error("negative terminal");
  property p_own;
    !o_busy && i_term_func_sel[15:8] != 8'h60 && i_term_func_sel[15:8] != 8'hC4 |=> o_term[1] == $past(i_term_func_state[1]);
  endproperty
  a_own: assert property (p_own) else $error("own function");
  property p_rdback; wb ##1 (i_reg_rd && !i_reg_wr && i_reg_idx == 2'h1) |=> o_reg_rdata == $past(i_reg_wdata, 2); endproperty
  a_rdback: assert property (p_rdback) else $error("read back");
  c_wb: cover property (wb);
  c_busy: cover property (rq && o_busy);
  c_b2b: cover property (wb ##1 i_reg_rd);
endmodule // rol_checker
bind remote_output_latch rol_checker u_chk (.i_ref_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_idx, .i_reg_wdata,
  .o_reg_rdata, .o_reg_ack, .o_reg_err, .i_term_func_sel, .i_term_func_state, .o_term, .o_busy);
`default_nettype wire

// file: tb/host_link.sv
/* Host computer model on the parameter port.
   Assumes the bench owns the clock and calls these tasks. */
`timescale 1ns/1ps
`default_nettype none
module host_link (
  input wire i_ref_clk, // Clock.
  output logic o_wr, // Write.
  output logic o_rd, // Read.
  output logic [1:0] o_idx, // Index.
  output logic [11:0] o_wdata, // Write data.
  output logic [15:0] o_func_sel, // Terminal codes.
  input wire i_ack, // Done.
  input wire i_err, // Refused.
  input wire [11:0] i_rdata // Read data.
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_idx = 2'h3;
    o_wdata = 12'hFFF;
    o_func_sel = 16'h0000;
  end
  task req(input logic w, input logic [1:0] i, input logic [11:0] d);
    @(posedge i_ref_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_idx = i;
    o_wdata = d;
  endtask
  // Released data is inverted so that a stale value never looks valid.
  task fin(output logic a, output logic e, output logic [11:0] q);
    @(posedge i_ref_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~o_wdata;
    a = i_ack;
    e = i_err;
    q = i_rdata;
  endtask
  task assign_func(input logic [7:0] t0, input logic [7:0] t1);
    o_func_sel = {t1, t0};
  endtask
endmodule // host_link
`default_nettype wire

// file: tb/remote_output_latch_bench.sv
/* Bench of the remote output latch.
   Assumes host_link and the checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module remote_output_latch_bench;
  logic i_ref_clk, i_rst_n, i_nv_rst_n, i_power_off, i_term_reset, i_comm_reset;
  logic [1:0] i_term_func_state;
  wire i_reg_wr, i_reg_rd, o_reg_ack, o_reg_err, o_busy;
  wire [1:0] i_reg_idx, o_term;
  wire [11:0] i_reg_wdata, o_reg_rdata;
  wire [15:0] i_term_func_sel;
  int n_mismatch = 0;
  int tests_run = 0;
  logic a, e;
  logic [11:0] q;
  logic [7:0] sels [4] = '{8'h00, 8'h01, 8'h0A, 8'h0B};
  remote_output_latch DUT (.i_ref_clk, .i_rst_n, .i_nv_rst_n, .i_power_off, .i_term_reset, .i_comm_reset,
    .i_reg_wr, .i_reg_rd, .i_reg_idx, .i_reg_wdata, .o_reg_rdata, .o_reg_ack, .o_reg_err,
    .i_term_func_sel, .i_term_func_state, .o_term, .o_busy);
  host_link host (.i_ref_clk, .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_idx(i_reg_idx), .o_wdata(i_reg_wdata),
    .o_func_sel(i_term_func_sel), .i_ack(o_reg_ack), .i_err(o_reg_err), .i_rdata(o_reg_rdata));
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task xfer(input logic w, input logic [1:0] i, input logic [11:0] d);
    host.req(w, i, d);
    host.fin(a, e, q);
    chk("ack", 12'h001, {11'h000, a});
  endtask
  task rd_chk(input string nm, input logic [1:0] i, input logic [11:0] exp);
    xfer(1'b0, i, 12'h000);
    chk(nm, exp, q);
  endtask
  task tchk(input logic [1:0] exp);
    @(posedge i_ref_clk);
    #1;
    chk("term", {10'h000, exp}, {10'h000, o_term});
  endtask
  task pulse(input int k);
    @(posedge i_ref_clk);
    #1;
    i_power_off = (k == 0);
    i_term_reset = (k == 1);
    i_comm_reset = (k == 2);
    @(posedge i_ref_clk);
    #1;
    {i_power_off, i_term_reset, i_comm_reset} = 3'h0;
  endtask
  task por;
    @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    // A write already standing when reset lets go meets the restore cycle.
    host.req(1'b1, 2'h1, 12'hFFF);
    i_rst_n = 1'b1;
    chk("busy_in_reset", 12'h001, {11'h000, o_busy});
    host.fin(a, e, q);
    chk("busy_refusal", 12'h003, {10'h000, a, e});
    chk("busy_after_restore", 12'h000, {11'h000, o_busy});
  endtask
  task close_out;
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
  initial begin
    {i_rst_n, i_nv_rst_n, i_power_off, i_term_reset, i_comm_reset} = 5'h00;
    i_term_func_state = 2'h2;
    repeat (16) @(posedge i_ref_clk);
    #1;
    {i_rst_n, i_nv_rst_n} = 2'h3;
    repeat (2) @(posedge i_ref_clk);
    rd_chk("sel", 2'h0, 12'h000);
    rd_chk("word", 2'h1, 12'h000);
    host.assign_func(8'h60, 8'hC4);
    xfer(1'b1, 2'h1, 12'h001);
    tchk(2'h3);
    xfer(1'b1, 2'h1, 12'hFFE);
    tchk(2'h0);
    host.assign_func(8'h60, 8'h00);
    xfer(1'b1, 2'h1, 12'hFFF);
    tchk(2'h3);
    i_term_func_state = 2'h0;
    tchk(2'h1);
    rd_chk("status", 2'h2, 12'h001);
    host.req(1'b1, 2'h1, 12'hABC);
    host.req(1'b0, 2'h1, 12'h000);
    host.fin(a, e, q);
    chk("b2b", 12'hABC, q);
    xfer(1'b1, 2'h3, 12'h000);
    chk("err", 12'h001, {11'h000, e});
    xfer(1'b1, 2'h2, 12'h000);
    chk("err_status_write", 12'h001, {11'h000, e});
    rd_chk("unmapped_read", 2'h3, 12'h000);
    chk("err_unmapped_read", 12'h001, {11'h000, e});
    xfer(1'b1, 2'h0, 12'h005);
    chk("err_sel_value", 12'h001, {11'h000, e});
    xfer(1'b1, 2'h0, 12'h10B);
    chk("err_sel_upper", 12'h001, {11'h000, e});
    rd_chk("sel_kept", 2'h0, 12'h000);
    rd_chk("word_kept", 2'h1, 12'hABC);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, 2'h0, {4'h0, sels[k]});
      xfer(1'b1, 2'h1, 12'h5A5);
      pulse(0);
      xfer(1'b1, 2'h1, 12'h3C3);
      pulse(1 + k % 2);
      rd_chk("inv", 2'h1, sels[k] == 8'h01 ? 12'h5A5 : (sels[k][3] ? 12'h3C3 : 12'h000));
      por;
      rd_chk("por", 2'h1, sels[k][0] ? 12'h5A5 : 12'h000);
      chk("term0", {11'h000, sels[k][0]}, {10'h000, o_term});
      rd_chk("selnv", 2'h0, {4'h0, sels[k]});
    end
    close_out;
  end
endmodule // remote_output_latch_bench
`default_nettype wire
